// ---- logic/cmps_core.sv ----
// Current-mode PWM core with jittered oscillator and soft start
`timescale 1ns/1ns
// Behaviour
// [RULE1] Oscillator sets latch; comparators clear it
// [RULE2] Sense plus ramp above feedback ends on-time
// [RULE3] Sense scaled by fixed gain 3.3
// [RULE4] 65 kHz, plus/minus 4 percent, 4 ms
// [RULE5] Jitter only after soft start completes
// [RULE6] Duty never above three quarters
// [RULE7] Ramp held in off phase, released at start
// [RULE8] Gate off about 156 ns after start
// [RULE9] Soft start begins at supply on-threshold
// [RULE10] Step every 600 us, 32 steps
// [RULE11] Soft start ends at 20 ms, sink off
// [RULE12] Allowed duty rises from zero to maximum
// [RULE13] Soft start restarts at each restart attempt
// [RULE14] Gate low while supply below off-threshold
// [RULE15] Peak limit clears latch every cycle
// [RULE16] Blank sense path at on-time start
// [RULE17] Burst flag enables lower 0.34 V limit
// [RULE18] Blanking lasts 220 ns
// [RULE19] Supply loss clears soft-start counter
// [RULE20] Burst flag after 20 ms low feedback
// [RULE21] Clear wins over coincident set
// [RULE22] Jitter is a symmetric triangle sweep
module cmps_core #(
  parameter int CW              = 13,
  parameter int SS_STEP_CYCLES  = cmps_pkg::SS_STEP_CYC,
  parameter int SS_DONE_CYCLES  = cmps_pkg::SS_TIME_CYC,
  parameter int JIT_CYCLES      = cmps_pkg::JIT_PERIOD_CYC,
  parameter int BURST_CYCLES    = cmps_pkg::BURST_BLANK_CYC
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          vcc_on,
  input  wire logic          restart_req,
  input  wire logic [CW-1:0] sense_mv,
  input  wire logic [CW-1:0] feedback_level,
  output logic               gate_drive,
  output logic               osc_phase_signal,
  output logic [CW-1:0]      ramp_up_level,
  output logic               soft_start_done,
  output logic               jitter_active,
  output logic               burst_flag
);
  import cmps_pkg::*;

  // ---------------------------------------------
  // Local sizes and checks
  // ---------------------------------------------
  localparam int PW = 11;
  localparam int TW = 22;
  localparam int SW = 16;
  localparam int JSTEP = JIT_CYCLES / (4 * JIT_SPAN_CYC);
  localparam logic [PW-1:0] NOM_P  = PW'(NOM_PERIOD_CYC);
  localparam logic [PW-1:0] MINOFF = PW'(MINOFF_CYC);
  localparam logic [4:0]    LEB    = 5'(LEB_CYC);
  localparam logic signed [7:0] JMAX = 8'(JIT_SPAN_CYC);
  localparam logic signed [7:0] JMIN = -JMAX;
  localparam logic [4:0]    SS_LAST = 5'(SS_STEPS - 1);

  if (CW < 13 || SS_STEP_CYCLES < 1 || JSTEP < 1 ||
      SS_DONE_CYCLES >= 2**TW || BURST_CYCLES >= 2**TW ||
      JIT_CYCLES >= 2**TW || BURST_CYCLES < 1) begin : g_chk
    $error("cmps_core: unsupported parameter values");
  end

  // ---------------------------------------------
  // Oscillator and jitter
  // ---------------------------------------------
  logic [PW-1:0]     cnt_r, cnt_nxt;
  logic [PW-1:0]     per_r, per_nxt;
  logic signed [7:0] jof_r, jof_nxt;
  logic              jdn_r, jdn_nxt;
  logic [TW-1:0]     jtk_r, jtk_nxt;
  logic [PW-1:0]     on_lim;
  logic              on_win;
  logic              cyc_start;
  logic [PW-1:0]     ramp;
  cmps_ss_t          ss_st_r, ss_st_nxt;
  logic              ss_done;

  assign ss_done   = (ss_st_r == SS_END);
  assign on_lim    = PW'((32'(per_r) * MAXD_NUM) / MAXD_DEN);
  assign on_win    = (cnt_r < on_lim); // [RULE6]
  assign cyc_start = (cnt_r == '0);
  // Ramp sits at zero through the off phase
  assign ramp      = on_win ? cnt_r : '0; // [RULE7]

  always_comb begin
    cnt_nxt = cnt_r + PW'(1);
    per_nxt = per_r;
    jof_nxt = jof_r;
    jdn_nxt = jdn_r;
    jtk_nxt = jtk_r;
    // New period only at wrap, so one cycle never changes length mid-way
    if (cnt_r >= per_r - PW'(1)) begin
      cnt_nxt = '0;
      per_nxt = PW'($signed({1'b0, NOM_P}) + jof_r); // [RULE4]
    end
    // Clear on the next state so a lockout never leaves a stale offset
    if (!ss_done || ss_st_nxt != SS_END) begin
      jof_nxt = '0; // [RULE5]
      jdn_nxt = 1'b0;
      jtk_nxt = '0;
    end else if (jtk_r == TW'(JSTEP - 1)) begin
      jtk_nxt = '0;
      if (!jdn_r) begin
        jof_nxt = jof_r + 8'sd1; // [RULE22]
        if (jof_r == JMAX - 8'sd1) begin
          jdn_nxt = 1'b1;
        end
      end else begin
        jof_nxt = jof_r - 8'sd1; // [RULE22]
        if (jof_r == JMIN + 8'sd1) begin
          jdn_nxt = 1'b0;
        end
      end
    end else begin
      jtk_nxt = jtk_r + TW'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      per_r <= NOM_P;
      jof_r <= '0;
      jdn_r <= 1'b0;
      jtk_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      jof_r <= jof_nxt;
      jdn_r <= jdn_nxt;
      jtk_r <= jtk_nxt;
    end
  end

  // ---------------------------------------------
  // Soft start sequencer
  // ---------------------------------------------
  logic [4:0]    ss_stp_r, ss_stp_nxt;
  logic [TW-1:0] ss_tk_r, ss_tk_nxt;
  logic [TW-1:0] ss_tm_r, ss_tm_nxt;
  logic [CW-1:0] ss_lvl_r, ss_lvl_nxt;
  logic          vcc_d_r;

  always_comb begin
    ss_st_nxt  = ss_st_r;
    ss_stp_nxt = ss_stp_r;
    ss_tk_nxt  = ss_tk_r;
    ss_tm_nxt  = ss_tm_r;
    if (!vcc_on) begin
      ss_st_nxt  = SS_OFF; // [RULE19]
      ss_stp_nxt = '0;
      ss_tk_nxt  = '0;
      ss_tm_nxt  = '0;
    end else if (restart_req || !vcc_d_r) begin
      ss_st_nxt  = SS_RUN; // [RULE9] [RULE13]
      ss_stp_nxt = '0;
      ss_tk_nxt  = '0;
      ss_tm_nxt  = '0;
    end else begin
      case (ss_st_r)
        SS_RUN: begin
          ss_tm_nxt = ss_tm_r + TW'(1);
          ss_tk_nxt = ss_tk_r + TW'(1);
          if (ss_tk_r == TW'(SS_STEP_CYCLES - 1)) begin
            ss_tk_nxt = '0;
            if (ss_stp_r != SS_LAST) begin
              ss_stp_nxt = ss_stp_r + 5'd1; // [RULE10]
            end
          end
          if (ss_tm_r == TW'(SS_DONE_CYCLES - 1)) begin
            ss_st_nxt = SS_END; // [RULE11]
          end
        end
        default: begin
          ss_st_nxt = ss_st_r;
        end
      endcase
    end
    // Step zero gives zero level, hence zero duty
    ss_lvl_nxt = CW'((32'(ss_stp_nxt) * SS_FULL_MV) / (SS_STEPS - 1)); // [RULE12]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ss_st_r  <= SS_OFF;
      ss_stp_r <= '0;
      ss_tk_r  <= '0;
      ss_tm_r  <= '0;
      ss_lvl_r <= '0;
      vcc_d_r  <= 1'b0;
    end else if (ce) begin
      ss_st_r  <= ss_st_nxt;
      ss_stp_r <= ss_stp_nxt;
      ss_tk_r  <= ss_tk_nxt;
      ss_tm_r  <= ss_tm_nxt;
      ss_lvl_r <= ss_lvl_nxt;
      vcc_d_r  <= vcc_on;
    end
  end

  // ---------------------------------------------
  // Cycle latch, blanking and gate
  // ---------------------------------------------
  logic          latch_r, latch_nxt;
  logic          gate_r, gate_nxt;
  logic [4:0]    blk_r, blk_nxt;
  logic          blank;
  logic [CW-1:0] sense_b;
  logic [SW-1:0] amp, sum;
  logic          duty_trip, ss_trip, peak_trip, bl_trip, clr;
  logic          burst_r, burst_nxt;

  assign blank   = (blk_r < LEB); // [RULE16] [RULE18]
  assign sense_b = blank ? '0 : sense_mv;
  assign amp     = SW'((32'(sense_b) * GAIN_NUM) / GAIN_DEN); // [RULE3]
  assign sum     = amp + SW'(ramp);
  assign duty_trip = (sum > SW'(feedback_level)); // [RULE2]
  // Sink is gone once soft start ends
  assign ss_trip   = !ss_done && (sum > SW'(ss_lvl_r)); // [RULE11]
  assign peak_trip = !blank && (sense_mv > CW'(CS_LIMIT_MV)); // [RULE15]
  assign bl_trip   = burst_r && !blank && (sense_mv > CW'(BURST_LIMIT_MV)); // [RULE17]
  assign clr = duty_trip || ss_trip || peak_trip || bl_trip || !on_win || !vcc_on;

  always_comb begin
    latch_nxt = latch_r;
    if (clr) begin
      latch_nxt = 1'b0; // [RULE21]
    end else if (cyc_start) begin
      latch_nxt = 1'b1; // [RULE1]
    end
    // Minimum off time lets duty fall smoothly to zero
    gate_nxt = latch_nxt && (cnt_r >= MINOFF) && on_win && vcc_on; // [RULE8] [RULE14]
    blk_nxt = blk_r;
    if (!gate_r) begin
      blk_nxt = '0;
    end else if (blk_r < LEB) begin
      blk_nxt = blk_r + 5'd1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latch_r <= 1'b0;
      gate_r  <= 1'b0;
      blk_r   <= '0;
    end else if (ce) begin
      latch_r <= latch_nxt;
      gate_r  <= gate_nxt;
      blk_r   <= blk_nxt;
    end
  end

  // ---------------------------------------------
  // Burst flag
  // ---------------------------------------------
  logic [TW-1:0] bcnt_r, bcnt_nxt;

  always_comb begin
    burst_nxt = burst_r;
    bcnt_nxt  = '0;
    if (!vcc_on) begin
      burst_nxt = 1'b0;
    end else if (burst_r) begin
      if (feedback_level > CW'(BURST_EXIT_MV)) begin
        burst_nxt = 1'b0;
      end
    end else if (feedback_level < CW'(BURST_ENTRY_MV)) begin
      bcnt_nxt = bcnt_r + TW'(1);
      if (bcnt_r == TW'(BURST_CYCLES - 1)) begin
        burst_nxt = 1'b1; // [RULE20]
        bcnt_nxt  = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      burst_r <= 1'b0;
      bcnt_r  <= '0;
    end else if (ce) begin
      burst_r <= burst_nxt;
      bcnt_r  <= bcnt_nxt;
    end
  end

  assign gate_drive       = gate_r;
  assign osc_phase_signal = !on_win;
  assign ramp_up_level    = ss_lvl_r;
  assign soft_start_done  = ss_done;
  assign jitter_active    = ss_done;
  assign burst_flag       = burst_r;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence gate_rise_s;
    ce && !gate_r ##1 ce && gate_r;
  endsequence

  sequence blank_hold_s;
    blank [*8];
  endsequence

  uvlo_gate_off_a: assert property (ce && !vcc_on |=> !gate_r) else $error("gate on in lockout"); // [RULE14]
  min_off_a: assert property (gate_rise_s |-> $past(cnt_r) >= MINOFF) else $error("min off violated"); // [RULE8]
  max_duty_a: assert property (ce && gate_r |-> $past(cnt_r) < $past(on_lim)) else $error("duty above max"); // [RULE6]
  peak_clear_a: assert property (ce && peak_trip |=> !gate_r && !latch_r) else $error("peak not cut"); // [RULE15]
  duty_clear_a: assert property (ce && duty_trip |=> !gate_r) else $error("duty trip ignored"); // [RULE2]
  burst_limit_a: assert property (ce && bl_trip |=> !gate_r) else $error("burst limit ignored"); // [RULE17]
  ramp_hold_a: assert property (osc_phase_signal |-> ramp == '0) else $error("ramp not held"); // [RULE7]
  jit_gated_a: assert property (!ss_done |-> jof_r == 8'sd0) else $error("jitter before done"); // [RULE5]
  jit_range_a: assert property (jof_r <= JMAX && jof_r >= JMIN) else $error("jitter out of span"); // [RULE22]
  ss_clear_a: assert property (ce && !vcc_on |=> ss_stp_r == '0 && !ss_done) else $error("ss not cleared"); // [RULE19]
  leb_span_a: assert property (gate_rise_s |-> blank_hold_s) else $error("blanking too short"); // [RULE16]
  set_win_a: assert property (ce && cyc_start && !clr |=> latch_r) else $error("latch not set"); // [RULE1]
  clr_win_a: assert property (ce && cyc_start && clr |=> !latch_r) else $error("set beat clear"); // [RULE21]
endmodule

// ---- logic/cmps_pkg.sv ----
// Shared constants and types of the current-mode PWM core
package cmps_pkg;
  // ---------------------------------------------
  // Clock and oscillator
  // ---------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int SW_FREQ_HZ     = 65_000;
  localparam int NOM_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
  localparam int JIT_PCT        = 4;
  localparam int JIT_SPAN_CYC   = NOM_PERIOD_CYC * JIT_PCT / 100;
  localparam int JIT_PERIOD_MS  = 4;
  localparam int JIT_PERIOD_CYC = JIT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int MAXD_NUM       = 3;
  localparam int MAXD_DEN       = 4;
  localparam int MINOFF_NS      = 156;
  localparam int MINOFF_CYC     = (MINOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int LEB_NS         = 220;
  localparam int LEB_CYC        = (LEB_NS * CLK_MHZ + 999) / 1000;
  // ---------------------------------------------
  // Soft start and burst timing
  // ---------------------------------------------
  localparam int SS_STEPS        = 32;
  localparam int SS_STEP_US      = 600;
  localparam int SS_STEP_CYC     = SS_STEP_US * CLK_MHZ;
  localparam int SS_TIME_MS      = 20;
  localparam int SS_TIME_CYC     = SS_TIME_MS * (CLK_HZ / 1000);
  localparam int BURST_BLANK_MS  = 20;
  localparam int BURST_BLANK_CYC = BURST_BLANK_MS * (CLK_HZ / 1000);
  // ---------------------------------------------
  // Analog levels as millivolt codes
  // ---------------------------------------------
  localparam int GAIN_NUM       = 33;
  localparam int GAIN_DEN       = 10;
  localparam int CS_LIMIT_MV    = 1000;
  localparam int BURST_LIMIT_MV = 340;
  localparam int BURST_ENTRY_MV = 1350;
  localparam int BURST_EXIT_MV  = 4000;
  localparam int SS_FULL_MV     = 4000;

  typedef enum logic [1:0] {SS_OFF, SS_RUN, SS_END} cmps_ss_t;
endpackage

// ---- sim/cmps_core_bench.sv ----
// Self-checking bench of the current-mode PWM core
`timescale 1ns/1ns
module cmps_core_bench;
  import cmps_pkg::*;
  typedef struct {int lo; int hi;} cmps_note_t;
  logic        clock = 1'b0, rstn = 1'b0, ce = 1'b1, vcc_on = 1'b0, restart_req = 1'b0;
  logic [12:0] sense_mv, ramp_up_level, feedback_level = 13'h1FFF, level = 13'h0000;
  logic        gate_drive, osc_phase_signal, soft_start_done, jitter_active, burst_flag;
  logic        po = 1'b0, gp = 1'b0, arm = 1'b0, seen = 1'b0;
  int          errors = 0, tests_run = 0, k = 0, w = 0, n = 0, fb = 0, pmin = 9999, pmax = 0;
  cmps_note_t  q[$];
  cmps_note_t  c;

  always #5 clock = ~clock;

  cmps_core #(.CW(13), .SS_STEP_CYCLES(400), .SS_DONE_CYCLES(13000), .JIT_CYCLES(976),
    .BURST_CYCLES(50)) u_dut (.clock(clock), .rstn(rstn), .ce(ce), .vcc_on(vcc_on),
    .restart_req(restart_req), .sense_mv(sense_mv), .feedback_level(feedback_level),
    .gate_drive(gate_drive), .osc_phase_signal(osc_phase_signal), .ramp_up_level(ramp_up_level),
    .soft_start_done(soft_start_done), .jitter_active(jitter_active), .burst_flag(burst_flag));
  cmps_sense_model u_sense (.clock(clock), .gate_drive(gate_drive), .level(level), .sense_mv(sense_mv));

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Note one pulse width window, then let the watcher judge it
  task automatic pulse(input int lo, input int hi);
    repeat (2) @(posedge clock);
    while (gate_drive !== 1'b0) @(posedge clock);
    q.push_back('{lo, hi});
    n = 0;
    while (q.size() > 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chk(q.size() == 0, "pulse missing");
  endtask

  // ----------------------------------------
  // Output watcher, settled at falling edge
  // ----------------------------------------
  always @(negedge clock) begin
    k++;
    if (po && !osc_phase_signal) begin
      if (seen) begin
        chk(k >= 1477 && k <= 1599, "period out of range");
        pmin = k < pmin ? k : pmin;
        pmax = k > pmax ? k : pmax;
      end
      seen = 1'b1;
      k = 0;
    end
    if (gate_drive && !gp) begin
      if (seen) chk(k == 17, "gate start delay");
      arm = q.size() > 0;
      w = 0;
    end
    if (gate_drive) w++;
    if (!gate_drive && gp) begin
      chk(!vcc_on || soft_start_done || w + 15 <= ramp_up_level, "soft start duty");
      if (arm) begin
        c = q.pop_front();
        chk(w >= c.lo && w <= c.hi, "pulse width");
      end
      arm = 1'b0;
    end
    po = osc_phase_signal;
    gp = gate_drive;
  end

  initial begin
    #1000000;
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(83020));
    repeat (12) @(posedge clock);
    @(negedge clock);
    chk(gate_drive === 1'b0 && ramp_up_level === 13'h0000, "reset outputs");
    chk(soft_start_done === 1'b0 && burst_flag === 1'b0, "reset flags");
    @(posedge clock);
    rstn <= 1'b1;
    vcc_on <= 1'b1;
    repeat (200) @(posedge clock);
    for (int i = 0; i < 32; i++) begin
      @(negedge clock);
      chk(ramp_up_level === 13'(i * 4000 / 31), "soft start step");
      repeat (400) @(posedge clock);
    end
    @(negedge clock);
    chk(soft_start_done === 1'b0 && jitter_active === 1'b0, "early done");
    repeat (200) @(posedge clock);
    chk(soft_start_done === 1'b1 && jitter_active === 1'b1, "late done");
    level <= 13'h0064;
    repeat (3) begin
      fb = 700 + $urandom % 400;
      feedback_level <= 13'(fb);
      pulse(fb - 345, fb - 345);
    end
    feedback_level <= 13'h000A;
    n = 0;
    repeat (3100) begin
      @(negedge clock);
      if (gate_drive !== 1'b0) n++;
    end
    chk(n == 0, "zero duty");
    level <= 13'h0000;
    feedback_level <= 13'h1FFF;
    pulse(1091, 1183);
    level <= 13'h044C;
    pulse(21, 25);
    level <= 13'h01F4;
    feedback_level <= 13'h0514;
    repeat (40) @(posedge clock);
    chk(burst_flag === 1'b0, "burst early");
    repeat (20) @(posedge clock);
    chk(burst_flag === 1'b1, "burst late");
    feedback_level <= 13'h0BB8;
    pulse(21, 25);
    feedback_level <= 13'h1FFF;
    repeat (3) @(posedge clock);
    chk(burst_flag === 1'b0, "burst exit");
    pulse(1091, 1183);
    level <= 13'h0000;
    restart_req <= 1'b1;
    @(posedge clock);
    restart_req <= 1'b0;
    repeat (3) @(posedge clock);
    chk(soft_start_done === 1'b0 && ramp_up_level === 13'h0000, "restart");
    n = 0;
    while (soft_start_done !== 1'b1 && n < 14000) begin
      @(posedge clock);
      n++;
    end
    chk(soft_start_done === 1'b1, "restart done");
    while (gate_drive !== 1'b1) @(posedge clock);
    ce <= 1'b0;
    repeat (10) @(posedge clock);
    chk(gate_drive === 1'b1 && soft_start_done === 1'b1, "ce freeze");
    ce <= 1'b1;
    vcc_on <= 1'b0;
    repeat (2) @(negedge clock);
    chk(gate_drive === 1'b0 && soft_start_done === 1'b0, "lockout gate");
    chk(ramp_up_level === 13'h0000, "lockout level");
    n = 0;
    repeat (2000) begin
      @(negedge clock);
      if (gate_drive !== 1'b0) n++;
    end
    chk(n == 0, "lockout holds gate");
    chk(pmin < 1538 && pmax > 1538, "jitter spread");
    end_sim();
  end
endmodule

// ---- sim/cmps_sense_model.sv ----
// Current sense resistor model facing the PWM core
`timescale 1ns/1ns
module cmps_sense_model (
  input  wire logic        clock,
  input  wire logic        gate_drive,
  input  wire logic [12:0] level,
  output logic      [12:0] sense_mv
);
  logic [4:0] on_r = 5'h00;
  // No current while off; turn-on spike beats the peak limit
  always @(posedge clock) begin
    on_r     <= gate_drive ? (on_r == 5'h1F ? on_r : on_r + 5'h01) : 5'h00;
    sense_mv <= !gate_drive ? 13'h0000 : (on_r < 5'h05 ? 13'h05DC : level);
  end
endmodule
